// [cfg_addr_decode.v]
// Combinational decoder: classifies a configuration address phase
`timescale 1ns/1ps
`include "cfg_fwd_defines.vh"
module cfg_addr_decode (
    input wire [31:0] i_addr,     // Address phase bits
    input wire [3:0] i_cmd,       // Bus command
    input wire i_from_primary,    // High for a primary-bus cycle
    input wire i_select,          // Primary config select, synchronised
    input wire [7:0] i_pri_bus,   // Primary bus number
    input wire [7:0] i_sec_bus,   // Secondary bus number
    input wire [7:0] i_sub_bus,   // Subordinate bus number
    output reg [2:0] o_kind,      // Decode result
    output reg [31:0] o_far_addr, // Address to drive on far bus
    output reg [3:0] o_far_cmd    // Command to drive on far bus
);
    wire is_cfg = (i_cmd == `CMD_CFG_READ) || (i_cmd == `CMD_CFG_WRITE);
    wire is_wr = (i_cmd == `CMD_CFG_WRITE);
    wire [7:0] bus = i_addr[23:16];
    wire [4:0] dev = i_addr[15:11];
    wire ones = (dev == `DEV_ALL_ONES) && (i_addr[10:8] == `FUNC_ALL_ONES);
    wire reg0 = (i_addr[7:2] == `REG_ZERO);
    wire in_range = (bus >= i_sec_bus) && (bus <= i_sub_bus);
    reg [15:0] idsel;

    // One-hot select pattern on bits 31:16 for devices 0..15 only
    always @*
    begin
        idsel = 16'h0000;
        if (dev <= `IDSEL_DEV_MAX)
            idsel[dev[3:0]] = 1'b1;
    end

    // Priority: special cycle before other Type 1 handling
    always @*
    begin
        o_kind = `DECODE_NONE;
        o_far_addr = i_addr;
        o_far_cmd = i_cmd;
        if (!is_cfg)
            o_kind = `DECODE_NONE; // Special cycles never claimed
        else if (i_from_primary)
        begin
            if (i_addr[1:0] == `CFG_TYPE0 && i_select)
                o_kind = `DECODE_OWN; // Function field unused
            else if (i_addr[1:0] == `CFG_TYPE1 && is_wr && ones && reg0
                     && bus == i_sec_bus)
            begin
                o_kind = `DECODE_SPECIAL;
                o_far_cmd = `CMD_SPECIAL; // Address kept as is
            end
            else if (i_addr[1:0] == `CFG_TYPE1 && bus == i_sec_bus)
            begin
                o_kind = `DECODE_CONVERT;
                o_far_addr = {idsel, 5'h00, i_addr[10:2], 2'h0};
            end
            else if (i_addr[1:0] == `CFG_TYPE1 && bus > i_sec_bus
                     && bus <= i_sub_bus)
                o_kind = `DECODE_DOWN;
        end
        else if (i_addr[1:0] == `CFG_TYPE1 && is_wr && ones)
        begin
            // Type 0 on secondary never decoded
            if (reg0 && bus == i_pri_bus)
            begin
                o_kind = `DECODE_SPECIAL;
                o_far_cmd = `CMD_SPECIAL;
            end
            else if (!in_range)
                o_kind = `DECODE_UP;
        end
    end
endmodule // cfg_addr_decode

// [cfg_forwarder.v]
// Configuration-cycle claim, translate and forward engine for a bridge
`timescale 1ns/1ps
`include "cfg_fwd_defines.vh"
module cfg_forwarder (
    input wire i_clk,                  // 100 MHz clock
    input wire i_rst,                  // Synchronous reset, active high
    input wire i_addr_valid,           // Address phase strobe (same domain)
    input wire i_from_primary,         // Cycle is on the primary bus
    input wire [31:0] i_addr,          // Address phase bits
    input wire [3:0] i_primary_cmd_byte_en_n, // Command / byte enables
    input wire i_primary_config_select, // Pin, synchronised here
    input wire i_more_phases,          // Initiator asks for more data
    input wire [31:0] i_wdata,         // Write data of the request
    input wire [31:0] i_own_rdata,     // Config space read word
    input wire i_pri_bus_wr,           // Load primary bus number
    input wire i_sec_bus_wr,           // Load secondary bus number
    input wire i_sub_bus_wr,           // Load subordinate bus number
    input wire [7:0] i_bus_num,        // Bus number write value
    input wire i_far_claim,            // Far-bus target claimed cycle
    input wire i_far_done,             // Far-bus data transfer completed
    input wire [31:0] i_far_rdata,     // Far-bus read data
    output wire o_primary_target_claim_n, // Primary claim, active low
    output reg o_claim,                // Claim on initiating bus
    output reg o_ready,                // Target ready with data
    output reg o_retry,                // Target retry
    output reg o_disconnect,           // Stop with the transfer
    output reg [31:0] o_rdata,         // Read data to initiator
    output reg o_own_wr,               // Write strobe into config space
    output reg o_far_start,            // Start cycle on far bus
    output reg [31:0] o_far_addr,      // Far-bus address
    output reg [3:0] o_far_cmd,        // Far-bus command
    output reg [31:0] o_far_wdata,     // Far-bus write data
    output reg o_far_master_abort,     // Far cycle ended unclaimed
    output reg [7:0] o_pri_bus,        // Primary bus number field
    output reg [7:0] o_sec_bus,        // Secondary bus number field
    output reg [7:0] o_sub_bus         // Subordinate bus number field
);
    localparam ST_IDLE = 2'h0;
    localparam ST_FAR = 2'h1;
    localparam ST_DONE = 2'h2;

    reg sel_meta;
    reg sel_sync;
    reg [1:0] state;
    reg [2:0] abort_cnt;
    reg [31:0] pend_addr;
    reg [3:0] pend_cmd;
    reg pend_upstream;
    reg pend_special;
    reg [31:0] done_data;
    reg ans_primary;
    wire [2:0] kind;
    wire [31:0] dec_addr;
    wire [3:0] dec_cmd;
    wire same_req;

    ////////////////////////////////////////////////////////////////////
    // Select pin comes from outside: two flops before decode
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            sel_meta <= 1'b0;
            sel_sync <= 1'b0;
        end
        else
        begin
            sel_meta <= i_primary_config_select;
            sel_sync <= sel_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Bus number fields, written by config-space logic
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            o_pri_bus <= 8'h00;
            o_sec_bus <= 8'h00;
            o_sub_bus <= 8'h00;
        end
        else
        begin
            if (i_pri_bus_wr)
                o_pri_bus <= i_bus_num;
            if (i_sec_bus_wr)
                o_sec_bus <= i_bus_num;
            if (i_sub_bus_wr)
                o_sub_bus <= i_bus_num;
        end
    end

    // Decoder compares live fields during the address phase
    cfg_addr_decode u_decode (
        .i_addr(i_addr),
        .i_cmd(i_primary_cmd_byte_en_n),
        .i_from_primary(i_from_primary),
        .i_select(sel_sync),
        .i_pri_bus(o_pri_bus),
        .i_sec_bus(o_sec_bus),
        .i_sub_bus(o_sub_bus),
        .o_kind(kind),
        .o_far_addr(dec_addr),
        .o_far_cmd(dec_cmd)
    );

    // Retries must repeat the identical cycle to match
    assign same_req = (i_addr == pend_addr) && (dec_cmd == pend_cmd)
                      && (i_from_primary != pend_upstream);

    // Side is registered with the claim; a moving bus side cannot glitch it
    assign o_primary_target_claim_n = ~(o_claim && ans_primary);

    ////////////////////////////////////////////////////////////////////
    // Delayed-transaction engine; own-space access bypasses it
    always @(posedge i_clk)
    begin
        if (i_rst)
        begin
            state <= ST_IDLE;
            abort_cnt <= 3'h0;
            pend_addr <= 32'h0000_0000;
            pend_cmd <= 4'h0;
            pend_upstream <= 1'b0;
            pend_special <= 1'b0;
            done_data <= 32'h0000_0000;
            o_claim <= 1'b0;
            o_ready <= 1'b0;
            o_retry <= 1'b0;
            o_disconnect <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_own_wr <= 1'b0;
            o_far_start <= 1'b0;
            o_far_addr <= 32'h0000_0000;
            o_far_cmd <= 4'h0;
            o_far_wdata <= 32'h0000_0000;
            o_far_master_abort <= 1'b0;
            ans_primary <= 1'b0;
        end
        else
        begin
            o_claim <= 1'b0;
            o_ready <= 1'b0;
            o_retry <= 1'b0;
            o_disconnect <= 1'b0;
            o_own_wr <= 1'b0;
            o_far_start <= 1'b0;
            o_far_master_abort <= 1'b0;
            ans_primary <= i_from_primary; // Side of the answered cycle
            // Own space: answered next cycle whatever the engine does
            if (i_addr_valid && kind == `DECODE_OWN)
            begin
                o_claim <= 1'b1;
                o_ready <= 1'b1;
                o_disconnect <= i_more_phases; // One Dword only
                o_rdata <= i_own_rdata; // All bytes, enables ignored
                o_own_wr <= (i_primary_cmd_byte_en_n == `CMD_CFG_WRITE);
            end
            case (state)
                ST_IDLE:
                begin
                    if (i_addr_valid && kind != `DECODE_NONE
                        && kind != `DECODE_OWN)
                    begin
                        // Latch request, retry, launch far cycle
                        o_claim <= 1'b1;
                        o_retry <= 1'b1;
                        pend_addr <= i_addr;
                        pend_cmd <= dec_cmd;
                        pend_upstream <= ~i_from_primary;
                        pend_special <= (kind == `DECODE_SPECIAL);
                        o_far_start <= 1'b1;
                        o_far_addr <= dec_addr;
                        o_far_cmd <= dec_cmd;
                        o_far_wdata <= i_wdata; // Data unchanged
                        abort_cnt <= 3'h0;
                        state <= ST_FAR;
                    end
                end
                ST_FAR:
                begin
                    if (i_addr_valid && kind != `DECODE_NONE
                        && kind != `DECODE_OWN)
                    begin
                        o_claim <= 1'b1;
                        o_retry <= 1'b1; // Still busy: retry everyone
                    end
                    if (i_far_claim && !pend_special)
                    begin
                        if (i_far_done)
                        begin
                            done_data <= i_far_rdata;
                            state <= ST_DONE;
                        end
                    end
                    else if (abort_cnt == `MASTER_ABORT_CYCLES - 3'h1)
                    begin
                        // Unclaimed for five clocks
                        o_far_master_abort <= 1'b1;
                        done_data <= 32'hFFFF_FFFF;
                        state <= ST_DONE; // Unclaimed or special cycle done
                    end
                    else
                        abort_cnt <= abort_cnt + 3'h1;
                end
                ST_DONE:
                begin
                    if (i_addr_valid && kind != `DECODE_NONE
                        && kind != `DECODE_OWN)
                    begin
                        o_claim <= 1'b1;
                        if (same_req)
                        begin
                            // Completion: one transfer only
                            o_ready <= 1'b1;
                            o_rdata <= done_data;
                            o_disconnect <= i_more_phases;
                            state <= ST_IDLE;
                        end
                        else
                            o_retry <= 1'b1;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end
endmodule // cfg_forwarder

// [cfg_fwd_defines.vh]
// Constants for the configuration-cycle decoder and forwarder
`ifndef CFG_FWD_DEFINES_VH
`define CFG_FWD_DEFINES_VH
`define CMD_CFG_READ 4'hA
`define CMD_CFG_WRITE 4'hB
`define CMD_SPECIAL 4'h1
`define CFG_TYPE0 2'h0
`define CFG_TYPE1 2'h1
`define DEV_ALL_ONES 5'h1F
`define FUNC_ALL_ONES 3'h7
`define REG_ZERO 6'h00
`define IDSEL_BASE 16
`define IDSEL_DEV_MAX 5'h0F
`define DECODE_NONE 3'h0
`define DECODE_OWN 3'h1
`define DECODE_CONVERT 3'h2
`define DECODE_DOWN 3'h3
`define DECODE_UP 3'h4
`define DECODE_SPECIAL 3'h5
`define MASTER_ABORT_CLOCKS 5
`define MASTER_ABORT_CYCLES 3'h5
`endif

// [far_target.sv]
// Far-bus target model answering forwarded cycles
`timescale 1ns/1ps
`include "cfg_fwd_defines.vh"
module far_target (
    input wire i_clk, // Clock
    input wire i_rst, // Reset
    input wire i_start, // Cycle start
    input wire [31:0] i_addr, // Far address
    input wire [3:0] i_cmd, // Far command
    input wire [1:0] i_delay, // Wait before claim
    output reg o_claim, // Claimed
    output reg o_done, // Transfer done
    output reg [31:0] o_rdata // Read data
);
reg busy;
reg [1:0] cnt;
// Claims only with a select line up; delay 3 answers too late, gets aborted
always @(posedge i_clk)
begin
    if (i_rst)
    begin
        busy <= 1'b0;
        cnt <= 2'h0;
        o_claim <= 1'b0;
        o_done <= 1'b0;
        o_rdata <= 32'h0;
    end
    else if (i_start)
    begin
        busy <= i_addr[31:16] != 16'h0 && i_cmd != `CMD_SPECIAL;
        cnt <= i_delay;
    end
    else if (busy && cnt == 2'h0)
    begin
        busy <= 1'b0;
        o_claim <= 1'b1;
        o_done <= 1'b1;
        o_rdata <= ~i_addr;
    end
    else
    begin
        cnt <= cnt - 2'h1;
        o_claim <= 1'b0;
        o_done <= 1'b0;
        o_rdata <= ~o_rdata; // Released lines invert their last value each clock
    end
end
endmodule // far_target

// [fwd_check_properties.sv]
// Port-level checks on the configuration forwarder
`timescale 1ns/1ps
`include "cfg_fwd_defines.vh"
module fwd_check (
    input wire i_clk, // Clock
    input wire i_rst, // Reset
    input wire i_addr_valid, // Strobe
    input wire i_from_primary, // Side
    input wire [31:0] i_addr, // Address
    input wire [3:0] i_primary_cmd_byte_en_n, // Command
    input wire i_more_phases, // Burst ask
    input wire o_primary_target_claim_n, // Claim pin
    input wire o_claim, // Claim
    input wire o_ready, // Ready
    input wire o_retry, // Retry
    input wire o_disconnect, // Stop
    input wire o_far_start, // Far start
    input wire [31:0] o_far_addr, // Far address
    input wire [3:0] o_far_cmd, // Far command
    input wire o_far_master_abort // Far abort
);
////////////////////////////////////////////////////////////////////////
// One clock domain, so one clocking and one disable for all
default clocking cb @(posedge i_clk);
endclocking
default disable iff (i_rst);
a_claim_pin: assert property (
    o_primary_target_claim_n == !(o_claim && $past(i_from_primary)))
    else $error("claim pin disagrees with claim");
a_claim_cause: assert property (o_claim |-> $past(i_addr_valid))
    else $error("claim without a request");
a_one_answer: assert property (o_claim |-> (o_ready ^ o_retry))
    else $error("claim needs exactly one of ready or retry");
a_sec_type0_ignored: assert property (
    i_addr_valid && !i_from_primary && i_addr[1:0] == `CFG_TYPE0
    |=> !o_claim) else $error("secondary type 0 claimed");
a_special_ignored: assert property (
    i_addr_valid && i_primary_cmd_byte_en_n == `CMD_SPECIAL
    |=> !o_claim && !o_far_start) else $error("special cycle taken");
a_burst_disconnect: assert property (
    i_addr_valid && i_more_phases ##1 o_ready |-> o_disconnect)
    else $error("burst not disconnected");
a_abort_timing: assert property (
    o_far_master_abort |-> $past(o_far_start, 5))
    else $error("abort not five clocks after start");
a_special_aborts: assert property (
    o_far_start && o_far_cmd == `CMD_SPECIAL |-> ##5 o_far_master_abort)
    else $error("special cycle not ended by abort");
a_type0_downward: assert property (
    o_far_start && o_far_addr[1:0] == `CFG_TYPE0 &&
    o_far_cmd != `CMD_SPECIAL |-> $past(i_from_primary))
    else $error("type 0 made on primary bus");
a_far_retried: assert property (o_far_start |-> o_retry)
    else $error("far start without retry");
endmodule // fwd_check
bind cfg_forwarder fwd_check chk (.i_clk, .i_rst, .i_addr_valid,
    .i_from_primary, .i_addr, .i_primary_cmd_byte_en_n, .i_more_phases,
    .o_primary_target_claim_n, .o_claim, .o_ready, .o_retry,
    .o_disconnect, .o_far_start, .o_far_addr, .o_far_cmd,
    .o_far_master_abort);

// [tb_top.sv]
// Self-checking bench for the configuration forwarder
`timescale 1ns/1ps
`include "cfg_fwd_defines.vh"
module tb_top;
reg i_clk = 1'b0;
reg i_rst = 1'b1;
reg i_addr_valid = 1'b0;
reg i_from_primary = 1'b0;
reg [31:0] i_addr = 32'h0;
reg [3:0] i_primary_cmd_byte_en_n = 4'h0;
reg i_primary_config_select = 1'b0;
reg i_more_phases = 1'b0;
reg [31:0] i_wdata = 32'h0;
reg [31:0] i_own_rdata = 32'h0;
reg [2:0] bus_wr = 3'h0;
reg [7:0] i_bus_num = 8'h0;
reg [1:0] delay = 2'h0;
reg [2:0] f;
reg [5:0] r;
wire i_far_claim, i_far_done, o_primary_target_claim_n, o_claim, o_ready;
wire o_retry, o_disconnect, o_own_wr, o_far_start, o_far_master_abort;
wire [31:0] i_far_rdata, o_rdata, o_far_addr, o_far_wdata;
wire [3:0] o_far_cmd;
wire [7:0] o_pri_bus, o_sec_bus, o_sub_bus;
integer seed = 89251;
integer n_errors = 0;
integer n_checks = 0;
integer seen_done = 0;
integer seen_ab = 0;
integer k, k2;
reg [36:0] q_resp[$];
reg [68:0] q_far[$];
always #5 i_clk = ~i_clk;
cfg_forwarder dut (.i_clk, .i_rst, .i_addr_valid, .i_from_primary, .i_addr,
    .i_primary_cmd_byte_en_n, .i_primary_config_select, .i_more_phases,
    .i_wdata, .i_own_rdata, .i_pri_bus_wr(bus_wr[2]),
    .i_sec_bus_wr(bus_wr[1]), .i_sub_bus_wr(bus_wr[0]), .i_bus_num,
    .i_far_claim, .i_far_done, .i_far_rdata, .o_primary_target_claim_n,
    .o_claim, .o_ready, .o_retry, .o_disconnect, .o_rdata, .o_own_wr,
    .o_far_start, .o_far_addr, .o_far_cmd, .o_far_wdata,
    .o_far_master_abort, .o_pri_bus, .o_sec_bus, .o_sub_bus);
far_target far (.i_clk, .i_rst, .i_start(o_far_start), .i_addr(o_far_addr),
    .i_cmd(o_far_cmd), .i_delay(delay), .o_claim(i_far_claim),
    .o_done(i_far_done), .o_rdata(i_far_rdata));
////////////////////////////////////////////////////////////////////////
// Count and report one comparison
task check(input ok, input [8*24:1] msg);
begin
    n_checks = n_checks + 1;
    if (!ok)
    begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t %0s", $time, msg);
    end
end
endtask
task wrap_up;
begin
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
        $display("Testbench passed");
    else
        $display("Testbench failed");
    $finish;
end
endtask
task cmp_resp;
    reg [36:0] e;
begin
    e = q_resp.pop_front();
    check({o_ready, o_retry, o_disconnect} === e[35:33],
        "response kind");
    check(o_own_wr === e[36], "config write strobe");
    if (e[32])
        check(o_rdata === e[31:0], "read data");
end
endtask
task cmp_far;
    reg [68:0] e;
begin
    e = q_far.pop_front();
    check({o_far_addr, o_far_cmd} === e[67:32],
        "far address or command");
    if (e[68])
        check(o_far_wdata === e[31:0], "far write data");
end
endtask
// Select is set 3 edges early because the pin is synchronised
task req(input fp, input sel, input [31:0] a, input [3:0] c, input m,
    input [31:0] wd, input [31:0] rd);
begin
    i_primary_config_select <= sel;
    repeat (3) @(posedge i_clk);
    i_addr_valid <= 1'b1;
    i_from_primary <= fp;
    i_addr <= a;
    i_primary_cmd_byte_en_n <= c;
    i_more_phases <= m;
    i_wdata <= wd;
    i_own_rdata <= rd;
    @(posedge i_clk);
    i_addr_valid <= 1'b0;
    repeat (2) @(posedge i_clk);
end
endtask
task own(input [3:0] c, input m);
    reg [31:0] rd;
begin
    rd = $random(seed);
    q_resp.push_back({c == `CMD_CFG_WRITE, 2'b10, m, c == `CMD_CFG_READ, rd});
    req(1'b1, 1'b1, $random(seed) & 32'hFFFF_FFFC, c, m, $random(seed), rd);
end
endtask
// Delayed request, an own access meanwhile, then the identical retry
task dly(input fp, input [31:0] a, input [3:0] c, input m,
    input [31:0] fa, input [3:0] fc);
    reg [31:0] wd;
begin
    wd = $random(seed);
    delay <= $random(seed);
    seen_done = 0;
    seen_ab = 0;
    q_resp.push_back({4'b0010, 33'h0});
    q_far.push_back({c == `CMD_CFG_WRITE, fa, fc, wd});
    req(fp, 1'b0, a, c, m, wd, 32'h0);
    own(`CMD_CFG_READ, 1'b0);
    // A different cycle while one is pending is only retried
    q_resp.push_back({4'b0010, 33'h0});
    req(fp, 1'b0, a ^ 32'h0000_0004, c, m, wd, 32'h0);
    for (k2 = 0; k2 < 40 && seen_done + seen_ab == 0; k2 = k2 + 1)
        @(posedge i_clk);
    if (seen_done + seen_ab == 0)
    begin
        check(1'b0, "far bus hang");
        wrap_up;
    end
    else
    begin
        // Unclaimed, late-claimed or special cycles end by master abort
        q_resp.push_back({3'b010, m, c == `CMD_CFG_READ,
            fc != `CMD_SPECIAL && fa[31:16] != 16'h0 && delay != 2'h3 ?
            ~fa : 32'hFFFF_FFFF});
        req(fp, 1'b0, a, c, m, wd, 32'h0);
    end
end
endtask
// Output watcher: stray answers with nothing queued are mismatches
always @(posedge i_clk)
begin
    if (!i_rst && i_far_done && i_far_claim)
        seen_done = 1;
    if (!i_rst && o_far_master_abort)
        seen_ab = 1;
    if (!i_rst && o_claim)
        if (q_resp.size() == 0) check(1'b0, "unexpected claim");
        else cmp_resp;
    if (!i_rst && o_far_start)
        if (q_far.size() == 0) check(1'b0, "unexpected far cycle");
        else cmp_far;
end
initial
begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'b0;
    check(o_sec_bus === 8'h00, "bus field reset");
    for (k = 0; k < 3; k = k + 1)
    begin
        @(posedge i_clk);
        bus_wr <= 3'h4 >> k;
        i_bus_num <= k == 0 ? 8'h01 : k == 1 ? 8'h05 : 8'h08;
        @(posedge i_clk);
        bus_wr <= 3'h0;
    end
    @(posedge i_clk);
    check({o_pri_bus, o_sec_bus, o_sub_bus} === 24'h010508, "bus");
    for (k = 0; k < 8; k = k + 1)
        own(k[0] ? `CMD_CFG_WRITE : `CMD_CFG_READ, k[1]);
    for (k = 0; k < 5; k = k + 1)
        req(k != 1, k != 0, {16'h0 | (k == 4 ? 8'h09 : 8'h05),
            16'h1A10 | (k == 4)}, k == 2 ? `CMD_SPECIAL : k == 3 ? 4'h6 :
            `CMD_CFG_READ, 1'b0, 32'h0, 32'h0);
    $display("test own space done");
    for (k = 0; k < 32; k = k + 1)
    begin
        f = $random(seed);
        r = $random(seed) | 6'h01;
        dly(1'b1, {16'h0005, k[4:0], f, r, 2'b01},
            k[0] ? `CMD_CFG_WRITE : `CMD_CFG_READ, k[1],
            {k < 16 ? 16'h1 << k[3:0] : 16'h0, 5'h0, f, r, 2'b00},
            k[0] ? `CMD_CFG_WRITE : `CMD_CFG_READ);
    end
    $display("test conversion done");
    dly(1'b1, 32'h0006_1A15, `CMD_CFG_READ, 1'b1, 32'h0006_1A15,
        `CMD_CFG_READ);
    dly(1'b1, 32'h0008_1A15, `CMD_CFG_WRITE, 1'b0, 32'h0008_1A15,
        `CMD_CFG_WRITE);
    dly(1'b0, 32'h0020_FF0D, `CMD_CFG_WRITE, 1'b0, 32'h0020_FF0D,
        `CMD_CFG_WRITE);
    dly(1'b1, 32'h0005_FF01, `CMD_CFG_WRITE, 1'b1, 32'h0005_FF01,
        `CMD_SPECIAL);
    dly(1'b0, 32'h0001_FF01, `CMD_CFG_WRITE, 1'b1, 32'h0001_FF01,
        `CMD_SPECIAL);
    $display("test forwarding done");
    repeat (10) @(posedge i_clk);
    check(q_resp.size() + q_far.size() == 0, "answers missing");
    wrap_up;
end
endmodule // tb_top
